// File: hw/sgc_cfg.svh
`ifndef SGC_CFG_SVH
`define SGC_CFG_SVH

// Register indices (low seven address bits)
`define SGC_GLOBAL_CONFIGURATION_IDX 7'h00
`define SGC_GSTAT_IDX 7'h01
`define SGC_WRCNT_IDX 7'h02
`define SGC_NODE_IDX 7'h03

// Address flag and datagram constants
`define SGC_WRITE_BIT 7
`define SGC_SYNC_BYTE 8'h05
`define SGC_REPLY_DEST 8'hff
`define SGC_CRC_POLY 8'h07

// Global configuration field positions
`define SGC_GC_EXTCAP 1
`define SGC_GC_SHAFT 3
`define SGC_GC_DIAG_INDEX 4
`define SGC_GC_DIAG_STEP 5
`define SGC_GC_MSTEP_FILT 6
`define SGC_GC_TEST_MODE 7

// Reset values
`define SGC_GLOBAL_CONFIGURATION_RST 10'h040
`define SGC_GSTAT_RST 3'h1
`define SGC_WRCNT_RST 8'h00
`define SGC_NODE_RST 4'h0

// Node configuration field: reply delay in bits 11:8
`define SGC_NODE_LSB 8

`endif

// File: hw/sgc_pkg.sv
package sgc_pkg;

  // Received datagram, already deframed by the line receiver
  typedef struct packed {
    logic valid;
    logic [7:0] sync;
    logic [7:0] node;
    logic [7:0] addr;
    logic [31:0] data;
    logic [7:0] crc;
  } sgc_dgram_t;

  // Read reply handed to the line transmitter
  typedef struct packed {
    logic valid;
    logic [7:0] dest;
    logic [7:0] addr;
    logic [31:0] data;
  } sgc_reply_t;

  // Register access classes, one-hot except SGC_ACC_NONE, which is zero
  typedef enum logic [3:0] {
    SGC_ACC_NONE = 4'h0,
    SGC_ACC_RO = 4'h1,
    SGC_ACC_WO = 4'h2,
    SGC_ACC_RW = 4'h4,
    SGC_ACC_RWC = 4'h8
  } sgc_access_t;

endpackage

// File: hw/sgc_crc8.sv
`timescale 1ns/1ps
`include "sgc_cfg.svh"

// Bit-serial CRC8 unrolled over a whole datagram, LSB of each byte first
module sgc_crc8 (
  input wire logic [55:0] msg,
  output logic [7:0] crc_short,
  output logic [7:0] crc_long
);

  logic [7:0] chain [0:56];

  assign chain[0] = 8'h00;

  // One shift stage per message bit, zero initial value
  genvar k;
  generate
    for (k = 0; k < 56; k = k + 1) begin : g_bit
      wire fb = chain[k][7] ^ msg[k];
      assign chain[k+1] = {chain[k][6:0], 1'b0} ^
                          (fb ? `SGC_CRC_POLY : 8'h00);
    end
  endgenerate

  // Read requests cover three bytes, writes seven
  assign crc_short = chain[24];
  assign crc_long = chain[56];

endmodule

// File: hw/sgc_regs.sv
`timescale 1ns/1ps
`include "sgc_cfg.svh"

module sgc_regs (
  input wire logic clk,
  input wire logic arst_n,
  input sgc_pkg::sgc_dgram_t dgram,
  input wire logic [1:0] node_sel,
  input wire logic [1:0] status_flag,
  input wire logic dir_in,
  input wire logic diag_normal,
  input wire logic index_flag,
  input wire logic gen_step,
  input wire logic fullstep_fast,
  input wire logic [19:0] step_time_raw,
  input wire logic [19:0] step_time_filt,
  output sgc_pkg::sgc_reply_t reply,
  output logic [9:0] global_configuration,
  output logic pump_cap_fitted,
  output logic dir_motor,
  output logic diag_out,
  output logic step_filter_on,
  output logic [19:0] step_interval_readback,
  output logic dir_analog_test_en,
  output logic [3:0] reply_delay
);

  // Reset release through two flops
  logic rst_s1_ff;
  logic rst_n_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  // CRC over sync, node, address and data as transmitted
  logic [55:0] crc_msg;
  logic [7:0] crc_short;
  logic [7:0] crc_long;
  assign crc_msg = {dgram.data[7:0], dgram.data[15:8], dgram.data[23:16],
                    dgram.data[31:24], dgram.addr, dgram.node, dgram.sync};

  sgc_crc8 u_crc (
    .msg(crc_msg),
    .crc_short(crc_short),
    .crc_long(crc_long)
  );

  // Datagram decode
  wire is_write;
  wire [6:0] reg_idx;
  wire own_node;
  wire crc_ok;
  wire accepted;
  wire wr_ok;
  wire rd_ok;
  assign is_write = dgram.addr[`SGC_WRITE_BIT];
  assign reg_idx = dgram.addr[6:0];
  assign own_node = dgram.node == {6'h00, node_sel};
  assign crc_ok = is_write ? (crc_long == dgram.crc)
                           : (crc_short == dgram.crc);
  assign accepted = dgram.valid && own_node && crc_ok &&
                    dgram.sync == `SGC_SYNC_BYTE;
  assign wr_ok = accepted && is_write;
  assign rd_ok = accepted && !is_write;

  sgc_pkg::sgc_access_t acc_class;
  assign acc_class = (reg_idx == `SGC_GLOBAL_CONFIGURATION_IDX) ? sgc_pkg::SGC_ACC_RW :
                     (reg_idx == `SGC_GSTAT_IDX) ? sgc_pkg::SGC_ACC_RWC :
                     (reg_idx == `SGC_WRCNT_IDX) ? sgc_pkg::SGC_ACC_RO :
                     (reg_idx == `SGC_NODE_IDX) ? sgc_pkg::SGC_ACC_WO :
                     sgc_pkg::SGC_ACC_NONE;

  // Permissions follow the class; unmapped indices take nothing
  wire can_write;
  wire can_read;
  assign can_write = acc_class == sgc_pkg::SGC_ACC_RW ||
                     acc_class == sgc_pkg::SGC_ACC_RWC ||
                     acc_class == sgc_pkg::SGC_ACC_WO;
  assign can_read = acc_class == sgc_pkg::SGC_ACC_RW ||
                    acc_class == sgc_pkg::SGC_ACC_RWC ||
                    acc_class == sgc_pkg::SGC_ACC_RO;

  wire wr_global_configuration;
  wire wr_gstat;
  wire wr_node;
  assign wr_global_configuration = wr_ok && can_write && reg_idx == `SGC_GLOBAL_CONFIGURATION_IDX;
  assign wr_gstat = wr_ok && can_write && reg_idx == `SGC_GSTAT_IDX;
  assign wr_node = wr_ok && can_write && reg_idx == `SGC_NODE_IDX;

  // Register state
  logic [9:0] global_configuration_ff;
  logic [2:0] gstat_ff;
  logic [7:0] wrcnt_ff;
  logic [3:0] node_ff;
  logic [9:0] nxt_global_configuration;
  logic [2:0] nxt_gstat;
  logic [7:0] nxt_wrcnt;
  logic [3:0] nxt_node;

  // all ten bits stored, software keeps 0 and 2 low
  assign nxt_global_configuration = wr_global_configuration ? dgram.data[9:0] : global_configuration_ff;
  // one clears, zero keeps, new event wins
  assign nxt_gstat = (gstat_ff & ~(wr_gstat ? dgram.data[2:0] : 3'h0)) |
                     {status_flag, 1'b0};
  // Counts every correct write, wrapping at 255
  assign nxt_wrcnt = wr_ok ? wrcnt_ff + 8'h01 : wrcnt_ff;
  assign nxt_node = wr_node ? dgram.data[`SGC_NODE_LSB +: 4] : node_ff;

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      global_configuration_ff <= `SGC_GLOBAL_CONFIGURATION_RST;
      gstat_ff <= `SGC_GSTAT_RST;
      wrcnt_ff <= `SGC_WRCNT_RST;
      node_ff <= `SGC_NODE_RST;
    end else begin
      global_configuration_ff <= nxt_global_configuration;
      gstat_ff <= nxt_gstat;
      wrcnt_ff <= nxt_wrcnt;
      node_ff <= nxt_node;
    end
  end

  // Read data selection; hidden or unmapped registers give zero
  wire [31:0] rd_raw;
  wire [31:0] rd_data;
  assign rd_raw = (reg_idx == `SGC_GLOBAL_CONFIGURATION_IDX) ? {22'h00_0000, global_configuration_ff} :
                  (reg_idx == `SGC_GSTAT_IDX) ? {29'h0000_0000, gstat_ff} :
                  (reg_idx == `SGC_WRCNT_IDX) ? {24'h00_0000, wrcnt_ff} :
                  32'h0000_0000;
  assign rd_data = can_read ? rd_raw : 32'h0000_0000;

  // Reply is a one-cycle pulse one clock after an accepted read
  sgc_pkg::sgc_reply_t reply_ff;
  sgc_pkg::sgc_reply_t nxt_reply;
  assign nxt_reply.valid = rd_ok;
  assign nxt_reply.dest = `SGC_REPLY_DEST;
  assign nxt_reply.addr = {1'b0, reg_idx};
  assign nxt_reply.data = rd_data;

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      reply_ff <= '0;
    end else if (rd_ok) begin
      reply_ff <= nxt_reply;
    end else begin
      reply_ff.valid <= 1'b0;
    end
  end

  // Step toggle for the diagnostic pin
  logic step_tgl_ff;
  wire nxt_step_tgl;
  assign nxt_step_tgl = gen_step ? ~step_tgl_ff : step_tgl_ff;

  // Configuration effects, computed from the stored bits
  wire nxt_dir_motor;
  wire nxt_diag;
  wire nxt_filter_on;
  wire [19:0] nxt_interval;
  assign nxt_dir_motor = dir_in ^ global_configuration_ff[`SGC_GC_SHAFT];
  // index flag on diag, takes priority over step view
  assign nxt_diag = global_configuration_ff[`SGC_GC_DIAG_INDEX] ? index_flag :
                    global_configuration_ff[`SGC_GC_DIAG_STEP] ? nxt_step_tgl :
                    diag_normal;
  // filter only above the fullstep threshold
  assign nxt_filter_on = global_configuration_ff[`SGC_GC_MSTEP_FILT] && fullstep_fast;
  assign nxt_interval = nxt_filter_on ? step_time_filt : step_time_raw;

  // Output flops so no pin sees decode glitches
  logic pump_cap_ff;
  logic dir_motor_ff;
  logic diag_ff;
  logic filter_on_ff;
  logic [19:0] interval_ff;
  logic test_en_ff;
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      step_tgl_ff <= 1'b0;
      pump_cap_ff <= 1'b0;
      dir_motor_ff <= 1'b0;
      diag_ff <= 1'b0;
      filter_on_ff <= 1'b0;
      interval_ff <= 20'h0_0000;
      test_en_ff <= 1'b0;
    end else begin
      step_tgl_ff <= nxt_step_tgl;
      pump_cap_ff <= global_configuration_ff[`SGC_GC_EXTCAP];
      dir_motor_ff <= nxt_dir_motor;
      diag_ff <= nxt_diag;
      filter_on_ff <= nxt_filter_on;
      interval_ff <= nxt_interval;
      test_en_ff <= global_configuration_ff[`SGC_GC_TEST_MODE];
    end
  end

  assign reply = reply_ff;
  assign global_configuration = global_configuration_ff;
  assign pump_cap_fitted = pump_cap_ff;
  assign dir_motor = dir_motor_ff;
  assign diag_out = diag_ff;
  assign step_filter_on = filter_on_ff;
  assign step_interval_readback = interval_ff;
  assign dir_analog_test_en = test_en_ff;
  assign reply_delay = node_ff;

endmodule

// File: dv/sgc_regs_assertions.sv
`timescale 1ns/1ps
module sgc_regs_assertions (
  input wire logic clk,
  input wire logic arst_n,
  input sgc_pkg::sgc_dgram_t dgram,
  input wire logic dir_in,
  input wire logic index_flag,
  input wire logic gen_step,
  input wire logic fullstep_fast,
  input wire logic [19:0] step_time_raw,
  input wire logic [19:0] step_time_filt,
  input wire logic [9:0] global_configuration,
  input wire logic pump_cap_fitted,
  input wire logic dir_motor,
  input wire logic diag_out,
  input wire logic step_filter_on,
  input wire logic [19:0] step_interval_readback,
  input wire logic dir_analog_test_en
);
  logic [2:0] up_ff;
  wire live = up_ff[2];
  // Outputs trail the synchronised reset, so hold off for four edges
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) up_ff <= 3'h0;
    else if (!live) up_ff <= up_ff + 3'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_rst; $rose(arst_n) |-> global_configuration == 10'h040; endproperty
  a_rst: assert property (p_rst) else $error("global_configuration reset");
  property p_wr;
    live && $changed(global_configuration) |-> $past(dgram.valid && dgram.addr == 8'h80);
  endproperty
  a_wr: assert property (p_wr) else $error("global_configuration write");
  property p_pump; live |-> pump_cap_fitted == $past(global_configuration[1]); endproperty
  a_pump: assert property (p_pump) else $error("pump cap");
  property p_dir; live |-> dir_motor == $past(dir_in ^ global_configuration[3]); endproperty
  a_dir: assert property (p_dir) else $error("dir_motor");
  property p_idx;
    live && $past(global_configuration[4]) |-> diag_out == $past(index_flag);
  endproperty
  a_idx: assert property (p_idx) else $error("diag index");
  property p_step;
    live && $past(global_configuration[5:4]) == 2'b10 && $past(global_configuration[5:4], 2) == 2'b10
      && $past(gen_step) |-> diag_out != $past(diag_out);
  endproperty
  a_step: assert property (p_step) else $error("diag step");
  property p_filt;
    live |-> step_filter_on == $past(global_configuration[6] & fullstep_fast);
  endproperty
  a_filt: assert property (p_filt) else $error("step filter");
  // Readback must follow the filter choice made one clock earlier
  property p_intv;
    live |-> step_interval_readback == ($past(global_configuration[6] & fullstep_fast) ?
      $past(step_time_filt) : $past(step_time_raw));
  endproperty
  a_intv: assert property (p_intv) else $error("step interval");
  property p_test; live |-> dir_analog_test_en == $past(global_configuration[7]); endproperty
  a_test: assert property (p_test) else $error("test mode");
endmodule

bind sgc_regs sgc_regs_assertions u_chk (.clk, .arst_n, .dgram, .dir_in,
  .index_flag, .gen_step, .fullstep_fast, .step_time_raw, .step_time_filt,
  .global_configuration, .pump_cap_fitted, .dir_motor, .diag_out, .step_filter_on,
  .step_interval_readback, .dir_analog_test_en);

// File: dv/sgc_host_model.sv
`timescale 1ns/1ps
module sgc_host_model (
  input wire logic go,
  input wire logic bad,
  input wire logic [7:0] node,
  input wire logic [7:0] addr,
  input wire logic [31:0] data,
  output sgc_pkg::sgc_dgram_t dgram
);
  logic [7:0] c;
  logic [55:0] m;
  // CRC8 from zero, each byte LSB first
  // Reads protect only sync, node and address
  always_comb begin
    c = 8'h00;
    m = {8'h05, node, addr, data};
    for (int k = 0; k < (addr[7] ? 7 : 3); k++)
      for (int j = 0; j < 8; j++)
        c = {c[6:0], 1'b0} ^ (c[7] ^ m[48 - 8 * k + j] ? 8'h07 : 8'h00);
    // Idle lines show inverses so stale fields never pass as live
    dgram = go ? {1'b1, m, c ^ {7'h0, bad}} : {1'b0, ~m, ~c};
  end
endmodule

// File: dv/sgc_regs_tb_top.sv
`timescale 1ns/1ps
module sgc_regs_tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic go = 1'b0;
  logic bad = 1'b0;
  logic [7:0] node = 8'h02;
  logic [7:0] addr = 8'h00;
  logic [31:0] data = 32'h0000_0000;
  logic [31:0] r = 32'h0000_14e7;
  logic [31:0] v;
  logic [4:0] pins = 5'h00;
  logic [3:0] reply_delay;
  sgc_pkg::sgc_dgram_t dgram;
  sgc_pkg::sgc_reply_t reply;
  logic [1:0] flag = 2'b00;
  logic [39:0] exp_q[$];
  logic [39:0] ex;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_wr = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  sgc_host_model host (.go, .bad, .node, .addr, .data, .dgram);
  sgc_regs uut (.clk, .arst_n, .dgram, .node_sel(2'b10),
    .status_flag(flag), .dir_in(pins[0]), .diag_normal(pins[1]),
    .index_flag(pins[2]), .gen_step(pins[3]), .fullstep_fast(pins[4]),
    .step_time_raw(r[19:0]), .step_time_filt(r[31:12]), .reply, .global_configuration(),
    .pump_cap_fitted(), .dir_motor(), .diag_out(), .step_filter_on(),
    .step_interval_readback(), .dir_analog_test_en(), .reply_delay);
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(string nm, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", nm, e, s);
    end
  endtask
  // One datagram pulse, then a spare cycle before the next
  task automatic xfer(logic [7:0] a, logic [31:0] d, logic b = 1'b0,
                      logic [7:0] n = 8'h02);
    @(negedge clk);
    {go, addr, data, bad, node} = {1'b1, a, d, b, n};
    @(negedge clk);
    go = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    exp_q.push_back({a, e});
    xfer(a, r);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    n_wr++;
    xfer(a, d);
  endtask
  // Plain xorshift so every run sees the same sequence
  function automatic logic [31:0] xorshift(logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Fresh pin levels every cycle; the cycle cap cuts a hang short
  always @(negedge clk) begin
    r = xorshift(r);
    pins = r[4:0];
    cycles++;
    if (cycles > 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // Each reply is matched against the oldest pending expectation
  // Looked at mid-cycle, while the one-cycle valid stands settled
  always @(negedge clk)
    if (reply.valid === 1'b1) begin
      ex = exp_q.size() ? exp_q.pop_front() : 40'hff_dead_beef;
      check("reply", ex[31:0], reply.data);
      check("reply_addr", {24'h0, ex[39:32]}, {24'h0, reply.addr});
      check("reply_dest", 32'h0000_00ff, {24'h0, reply.dest});
    end
  initial begin
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    rd(8'h00, 32'h0000_0040);
    rd(8'h01, 32'h0000_0001);
    wr(8'h81, 32'h0000_0000);
    rd(8'h01, 32'h0000_0001);
    wr(8'h81, 32'h0000_0001);
    rd(8'h01, 32'h0000_0000);
    // Event flags latch; a clear in the same cycle as an event loses
    flag = 2'b11;
    @(negedge clk);
    flag = 2'b00;
    rd(8'h01, 32'h0000_0006);
    flag = 2'b11;
    wr(8'h81, 32'h0000_0006);
    flag = 2'b00;
    rd(8'h01, 32'h0000_0006);
    wr(8'h81, 32'h0000_0006);
    rd(8'h01, 32'h0000_0000);
    $display("defaults and status done");
    for (int i = 0; i < 9; i++) begin
      // Bits 0 and 2 stay zero; two fixed diag modes first
      v = i == 0 ? 32'h0000_0020 : i == 1 ? 32'h0000_0010 : r & 32'h0000_03fa;
      wr(8'h80, v);
      rd(8'h00, v);
      repeat (10) @(negedge clk);
    end
    $display("config writes done");
    // Refused writes carry a value that always differs from the stored one
    xfer(8'h80, v ^ 32'h0000_0008, 1'b1);
    xfer(8'h80, v ^ 32'h0000_0008, 1'b0, 8'h01);
    rd(8'h00, v);
    wr(8'h82, 32'h0000_00aa);
    wr(8'h83, 32'h0000_0500);
    check("reply_delay", 32'h0000_0005, {28'h0, reply_delay});
    rd(8'h03, 32'h0000_0000);
    rd(8'h02, 32'(n_wr));
    $display("refusals and access classes done");
    // Mid-run reset, once the last reply has been taken
    repeat (2) @(negedge clk);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    check("reply_delay", 32'h0000_0000, {28'h0, reply_delay});
    rd(8'h00, 32'h0000_0040);
    rd(8'h02, 32'h0000_0000);
    // Let the last reply arrive before counting what is left
    repeat (2) @(negedge clk);
    check("pending", 32'h0000_0000, 32'(exp_q.size()));
    $display("mid-run reset done");
    tally_and_finish();
  end
endmodule
